/* File: logic/sched_defs.svh */
`ifndef SCHED_DEFS_SVH
`define SCHED_DEFS_SVH

// Pipeline stage numbers for the lengthening add
`define OPERAND_READ_STAGE 3'h1
`define RESULT_FORWARD_STAGE 3'h3
`define LONG_ADD_LAT (`RESULT_FORWARD_STAGE - `OPERAND_READ_STAGE)

// Queue sizing defaults
`define IQ_ADDR_BITS 3
`define DQ_DEPTH_DEF 8

// Alignment masks on the low address bits
`define REG_ALIGN_MASK 5'h03
`define ALIGN_MASK_8 5'h07
`define ALIGN_MASK_16 5'h0F
`define ALIGN_MASK_32 5'h1F

// Reset values
`define SYSREG_RESET 32'h0000_0000
`define REM_RESET 3'h0

`endif

/* File: logic/sched_pkg.sv */
package sched_pkg;

  typedef enum logic [3:0] {
    CLS_LOAD = 4'h0,
    CLS_STORE = 4'h1,
    CLS_PERM = 4'h2,
    CLS_MOV_TO_CORE = 4'h3,
    CLS_MOV_FROM_CORE = 4'h4,
    CLS_SYSREG_RD = 4'h5,
    CLS_SYSREG_WR = 4'h6,
    CLS_DP = 4'h7,
    CLS_LONG_ADD = 4'h8
  } cls_type;

  typedef enum logic [2:0] {
    UNIT_ALU = 3'h0,
    UNIT_SHIFT = 3'h1,
    UNIT_MAC = 3'h2,
    UNIT_FADD = 3'h3,
    UNIT_FMUL = 3'h4
  } unit_type;

  typedef enum logic [2:0] {
    ST_START = 3'h1,
    ST_MID = 3'h2,
    ST_LAST = 3'h4
  } state_type;

  typedef enum logic [1:0] {
    KIND_CONTIG = 2'h0,
    KIND_STRUCT = 2'h1,
    KIND_MULTI_REG = 2'h2,
    KIND_SINGLE_REG = 2'h3
  } kind_type;

  typedef struct packed {
    cls_type cls;
    logic [2:0] unit;
    logic [4:0] dst;
    logic [4:0] src1;
    logic [4:0] src2;
    logic dst_quad;
    logic src_quad;
    logic [2:0] cycles;
    logic [2:0] latency;
    logic [31:0] data;
  } instr_type;

endpackage

/* File: logic/queue_mem.sv */
`timescale 1ns/100ps
module queue_mem #(
  parameter int WIDTH = 62,
  parameter int AW = 3
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [WIDTH-1:0] wdata,
  input wire logic [AW-1:0] raddr0,
  input wire logic [AW-1:0] raddr1,
  output logic [WIDTH-1:0] rdata0,
  output logic [WIDTH-1:0] rdata1
);
  logic [WIDTH-1:0] mem [1<<AW];

  // Storage array, no reset needed on the words themselves
  always_ff @(posedge sys_clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // Registered reads; a word written this cycle is passed straight through
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rdata0 <= '0;
      rdata1 <= '0;
    end else begin
      rdata0 <= (we && waddr == raddr0) ? wdata : mem[raddr0];
      rdata1 <= (we && waddr == raddr1) ? wdata : mem[raddr1];
    end
  end
endmodule

/* File: logic/simd_issue_scheduler.sv */
`timescale 1ns/100ps
`include "sched_defs.svh"

// Notes on behaviour
// - The host stalls new SIMD instructions while the instruction or data queue is full.
// - An instruction accepted into the queue counts as retired for the host pipeline.
// - Without the SIMD unit every SIMD instruction raises an undefined instruction exception.
// - After a SIMD-to-core move, general register access waits for all pending transfers.
// - Core-to-SIMD moves are handled exactly like memory loads.
// - Dual issue pairs only one load/store/permute/transfer with one data-processing op.
// - Transfer-type ops go to the load-store-permute pipe, data ops to the arithmetic pipes.
// - A multi-cycle op pairs only on its last cycle, or on its first when it is the newer op; middle cycles issue alone.
// - Quad register n aliases doubleword 2n (low half) and 2n+1 (high half).
// - The lengthening add reads sources at stage one and forwards its result from stage three.
// - Contiguous loads copy memory as is, structure accesses interleave 2 to 4 ways.
// - The two-way load places even elements in the first register and odd in the second.
// - Register loads and stores need alignment, structure loads only when encoded.
// - System register moves carry flags and control between the unit and the core.
// - Interleaved SIMD ops take about one issue cycle and run alongside host work.
module simd_issue_scheduler
  import sched_pkg::*;
#(
  parameter int IQ_AW = `IQ_ADDR_BITS,
  parameter int DQ_DEPTH = `DQ_DEPTH_DEF
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic simd_present,
  input wire logic host_valid,
  input wire cls_type host_cls,
  input wire logic [2:0] host_unit,
  input wire logic [4:0] host_dst,
  input wire logic [4:0] host_src1,
  input wire logic [4:0] host_src2,
  input wire logic host_dst_quad,
  input wire logic host_src_quad,
  input wire logic [2:0] host_cycles,
  input wire logic [2:0] host_latency,
  input wire logic [31:0] host_data,
  input wire logic host_xfer_ack,
  input wire logic fmt_valid,
  input wire logic fmt_store,
  input wire logic fmt_quad,
  input wire logic [2:0] fmt_ways,
  input wire logic [1:0] fmt_esize,
  input wire kind_type fmt_kind,
  input wire logic [4:0] fmt_addr_lo,
  input wire logic [1:0] fmt_align,
  input wire logic [255:0] fmt_data,
  output logic host_stall_reg,
  output logic retire_reg,
  output logic undef_exc_reg,
  output logic gpr_stall_reg,
  output logic lsp_issue_reg,
  output cls_type lsp_cls_reg,
  output logic dp_issue_reg,
  output logic [2:0] dp_unit_reg,
  output logic dual_issue_reg,
  output logic interlock_stall_reg,
  output logic xfer_valid_reg,
  output logic [31:0] xfer_data_reg,
  output logic fmt_out_valid_reg,
  output logic [255:0] fmt_out_reg,
  output logic align_fault_reg
);
  localparam int IQ_DEPTH = 1 << IQ_AW;
  localparam int DQW = $clog2(DQ_DEPTH + 1);

  logic present_meta_reg, present_sync_reg;
  logic [IQ_AW-1:0] wr_ptr_reg, rd_ptr_reg, rd_ptr_next;
  logic [IQ_AW:0] iq_count_reg, iq_count_next;
  logic [DQW-1:0] dq_count_reg, dq_count_next;
  logic [3:0] pend_reg, pend_next;
  state_type state_reg, state_next;
  logic [2:0] rem_reg, rem_next;
  logic [2:0] busy_reg [32];
  logic [31:0] busy_vec, hmask, nmask;
  logic [31:0] sysreg_reg;
  instr_type push_ins, head_ins, next_ins, lsp_ins;
  logic push, head_ok, head_hazard, head_go, head_last, head_first, pair_ok;
  logic lsp_first, dp_go;
  logic [1:0] pops, dq_pops;

  // Load-store-permute pipe takes memory, permute and transfer classes
  function automatic logic is_lsp(cls_type c);
    return !(c == CLS_DP || c == CLS_LONG_ADD);
  endfunction

  function automatic logic needs_data(cls_type c);
    return c == CLS_LOAD || c == CLS_STORE || c == CLS_MOV_FROM_CORE || c == CLS_SYSREG_WR;
  endfunction

  function automatic logic to_core(cls_type c);
    return c == CLS_MOV_TO_CORE || c == CLS_SYSREG_RD;
  endfunction

  // Core-to-SIMD moves write a register just like a load
  function automatic logic writes_reg(cls_type c);
    return c == CLS_LOAD || c == CLS_MOV_FROM_CORE || c == CLS_PERM || !is_lsp(c);
  endfunction

  // Doubleword mask of an operand; a quad covers 2n and 2n+1
  function automatic logic [31:0] d_mask(logic [4:0] idx, logic quad);
    return quad ? (32'h0000_0003 << {idx[3:0], 1'b0}) : (32'h0000_0001 << idx);
  endfunction

  function automatic logic [31:0] src_mask(instr_type i);
    return d_mask(i.src1, i.src_quad) | d_mask(i.src2, i.src_quad);
  endfunction

  // Stall cycles a reader sees after issue: latency (result stage minus read stage for the long add), less one
  function automatic logic [2:0] hold_of(instr_type i);
    logic [2:0] lat;
    lat = (i.cls == CLS_LONG_ADD) ? `LONG_ADD_LAT : i.latency;
    return (lat == 3'h0) ? 3'h0 : lat - 3'h1;
  endfunction

  function automatic state_type state_of(logic [2:0] rem);
    return (rem == 3'h1) ? ST_LAST : ST_MID;
  endfunction

  // Byte shuffle for structure accesses; a store runs the map the other way
  function automatic logic [255:0] shuffle(logic [255:0] d, logic [2:0] ways,
                                           logic [1:0] esz, logic quad, logic st);
    int eb, pb, w, b, sb;
    logic [255:0] o;
    o = '0;
    eb = 1 << esz;
    pb = quad ? 16 : 8;
    for (int ob = 0; ob < 32; ob++) begin
      w = ob / pb;
      b = ob % pb;
      sb = ((b / eb) * int'(ways) + w) * eb + (b % eb);
      if (w < int'(ways) && sb < 32) begin
        if (st) begin
          o[sb*8 +: 8] = d[ob*8 +: 8];
        end else begin
          o[ob*8 +: 8] = d[sb*8 +: 8];
        end
      end
    end
    return o;
  endfunction

  assign push_ins = '{cls: host_cls, unit: host_unit, dst: host_dst, src1: host_src1,
                      src2: host_src2, dst_quad: host_dst_quad, src_quad: host_src_quad,
                      cycles: host_cycles, latency: host_latency, data: host_data};

  queue_mem #(.WIDTH($bits(instr_type)), .AW(IQ_AW)) u_queue (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .we(push),
    .waddr(wr_ptr_reg),
    .wdata(push_ins),
    .raddr0(rd_ptr_next),
    .raddr1(IQ_AW'(rd_ptr_next + 1'b1)),
    .rdata0(head_ins),
    .rdata1(next_ins)
  );

  // Presence strap comes from outside, so it is synchronised first
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      present_meta_reg <= 1'b0;
      present_sync_reg <= 1'b0;
    end else begin
      present_meta_reg <= simd_present;
      present_sync_reg <= present_meta_reg;
    end
  end

  // Issue decision for the oldest two queue entries
  always_comb begin
    push = host_valid && !host_stall_reg && present_sync_reg;
    head_ok = iq_count_reg != '0;
    head_hazard = head_ok && state_reg == ST_START && |(src_mask(head_ins) & busy_vec);
    head_go = head_ok && !head_hazard;
    head_first = head_go && state_reg == ST_START;
    head_last = (state_reg == ST_START && head_ins.cycles <= 3'h1) || state_reg == ST_LAST;
    // Newer op pairs only in the head's last cycle, never in a middle one
    pair_ok = head_go && head_last && iq_count_reg > (IQ_AW+1)'(1)
              && is_lsp(head_ins.cls) != is_lsp(next_ins.cls)
              && !(|(src_mask(next_ins) & (busy_vec | hmask)));
    pops = 2'h0;
    state_next = state_reg;
    rem_next = rem_reg;
    if (head_go) begin
      case (state_reg)
        ST_START: begin
          if (head_ins.cycles > 3'h1) begin
            rem_next = head_ins.cycles - 3'h1;
            state_next = state_of(rem_next);
          end else begin
            pops = 2'h1;
          end
        end
        ST_MID: begin
          rem_next = rem_reg - 3'h1;
          state_next = state_of(rem_next);
        end
        ST_LAST: begin
          pops = 2'h1;
          state_next = ST_START;
        end
        default: begin
          state_next = ST_START;
        end
      endcase
      if (pair_ok) begin
        if (next_ins.cycles > 3'h1) begin
          rem_next = next_ins.cycles - 3'h1;
          state_next = state_of(rem_next);
        end else begin
          pops = 2'h2;
          state_next = ST_START;
        end
      end
    end
    lsp_ins = is_lsp(head_ins.cls) ? head_ins : next_ins;
    lsp_first = (head_first && is_lsp(head_ins.cls)) || (pair_ok && is_lsp(next_ins.cls));
    dp_go = (head_go && !is_lsp(head_ins.cls)) || (pair_ok && !is_lsp(next_ins.cls));
    dq_pops = {1'b0, head_first && needs_data(head_ins.cls)}
              + {1'b0, pair_ok && needs_data(next_ins.cls)};
    rd_ptr_next = rd_ptr_reg + IQ_AW'(pops);
    iq_count_next = iq_count_reg + (IQ_AW+1)'(push) - (IQ_AW+1)'(pops);
    dq_count_next = dq_count_reg + DQW'(push && needs_data(host_cls)) - DQW'(dq_pops);
    pend_next = pend_reg + 4'(lsp_first && to_core(lsp_ins.cls)) - 4'(host_xfer_ack);
  end

  // Destination masks and busy flags of the scoreboard
  always_comb begin
    hmask = (head_first && writes_reg(head_ins.cls)) ? d_mask(head_ins.dst, head_ins.dst_quad) : '0;
    nmask = (pair_ok && writes_reg(next_ins.cls)) ? d_mask(next_ins.dst, next_ins.dst_quad) : '0;
    for (int i = 0; i < 32; i++) begin
      busy_vec[i] = busy_reg[i] != 3'h0;
    end
  end

  // Scoreboard countdown; the younger writer wins a shared register
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < 32; i++) begin
        busy_reg[i] <= 3'h0;
      end
    end else begin
      for (int i = 0; i < 32; i++) begin
        if (nmask[i]) begin
          busy_reg[i] <= hold_of(next_ins);
        end else if (hmask[i]) begin
          busy_reg[i] <= hold_of(head_ins);
        end else if (busy_vec[i]) begin
          busy_reg[i] <= busy_reg[i] - 3'h1;
        end
      end
    end
  end

  // Queue pointers, counts and host-facing handshake
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      iq_count_reg <= '0;
      dq_count_reg <= '0;
      pend_reg <= 4'h0;
      host_stall_reg <= 1'b0;
      gpr_stall_reg <= 1'b0;
      retire_reg <= 1'b0;
      undef_exc_reg <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      rd_ptr_reg <= rd_ptr_next;
      iq_count_reg <= iq_count_next;
      dq_count_reg <= dq_count_next;
      pend_reg <= pend_next;
      // Full is judged on next counts so the stall is exact a cycle later
      host_stall_reg <= iq_count_next == (IQ_AW+1)'(IQ_DEPTH)
                        || dq_count_next == DQW'(DQ_DEPTH);
      gpr_stall_reg <= pend_next != 4'h0;
      retire_reg <= push;
      undef_exc_reg <= host_valid && !present_sync_reg;
    end
  end

  // Multi-cycle sequencing state
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= ST_START;
      rem_reg <= `REM_RESET;
    end else begin
      state_reg <= state_next;
      rem_reg <= rem_next;
    end
  end

  // Pipe issue strobes, one op per pipe per cycle
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      lsp_issue_reg <= 1'b0;
      lsp_cls_reg <= CLS_LOAD;
      dp_issue_reg <= 1'b0;
      dp_unit_reg <= 3'h0;
      dual_issue_reg <= 1'b0;
      interlock_stall_reg <= 1'b0;
    end else begin
      lsp_issue_reg <= (head_go && is_lsp(head_ins.cls)) || (pair_ok && is_lsp(next_ins.cls));
      lsp_cls_reg <= lsp_ins.cls;
      dp_issue_reg <= dp_go;
      dp_unit_reg <= is_lsp(head_ins.cls) ? next_ins.unit : head_ins.unit;
      dual_issue_reg <= pair_ok;
      interlock_stall_reg <= head_hazard;
    end
  end

  // System register moves and transfers toward the core
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      sysreg_reg <= `SYSREG_RESET;
      xfer_valid_reg <= 1'b0;
      xfer_data_reg <= 32'h0000_0000;
    end else begin
      if (lsp_first && lsp_ins.cls == CLS_SYSREG_WR) begin
        sysreg_reg <= lsp_ins.data;
      end
      xfer_valid_reg <= lsp_first && to_core(lsp_ins.cls);
      if (lsp_first && to_core(lsp_ins.cls)) begin
        xfer_data_reg <= (lsp_ins.cls == CLS_SYSREG_RD) ? sysreg_reg : {27'h0, lsp_ins.src1};
      end
    end
  end

  // Load and store data formatting with alignment checks
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      fmt_out_valid_reg <= 1'b0;
      fmt_out_reg <= '0;
      align_fault_reg <= 1'b0;
    end else begin
      fmt_out_valid_reg <= fmt_valid;
      if (fmt_valid) begin
        fmt_out_reg <= (fmt_kind == KIND_STRUCT)
                       ? shuffle(fmt_data, fmt_ways, fmt_esize, fmt_quad, fmt_store)
                       : fmt_data;
      end
      case (fmt_kind)
        KIND_MULTI_REG, KIND_SINGLE_REG: begin
          align_fault_reg <= fmt_valid && |(fmt_addr_lo & `REG_ALIGN_MASK);
        end
        default: begin
          align_fault_reg <= fmt_valid && fmt_align != 2'h0 && |(fmt_addr_lo &
            (fmt_align == 2'h1 ? `ALIGN_MASK_8 :
             fmt_align == 2'h2 ? `ALIGN_MASK_16 : `ALIGN_MASK_32));
        end
      endcase
    end
  end
endmodule

/* File: test/sched_chk.sv */
`timescale 1ns/100ps
module sched_chk
  import sched_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic host_valid,
  input wire logic host_stall_reg,
  input wire logic retire_reg,
  input wire logic undef_exc_reg,
  input wire logic lsp_issue_reg,
  input wire cls_type lsp_cls_reg,
  input wire logic dp_issue_reg,
  input wire logic [2:0] dp_unit_reg,
  input wire logic dual_issue_reg,
  input wire logic interlock_stall_reg,
  input wire logic xfer_valid_reg,
  input wire logic host_xfer_ack,
  input wire logic gpr_stall_reg,
  input wire logic fmt_valid,
  input wire logic fmt_out_valid_reg
);
  // One clock domain, so clock and reset are stated once
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rstn);

  // Offers and their answers
  a_take_retire: assert property (retire_reg |->
    $past(host_valid) && !$past(host_stall_reg)) else $error("retire without offer");
  a_undef_alone: assert property (undef_exc_reg |->
    !retire_reg && $past(host_valid)) else $error("undefined without offer");
  // Pairing and pipe routing
  a_pair_only: assert property (dual_issue_reg |->
    lsp_issue_reg && dp_issue_reg) else $error("dual flag without two pipes");
  a_pair_flag: assert property (lsp_issue_reg && dp_issue_reg |->
    dual_issue_reg) else $error("two pipes without dual flag");
  a_lsp_class: assert property (lsp_issue_reg |->
    !(lsp_cls_reg inside {CLS_DP, CLS_LONG_ADD})) else $error("data op in lsp pipe");
  a_dp_unit: assert property (dp_issue_reg |-> dp_unit_reg <= 3'h4)
    else $error("bad arithmetic pipe");
  // A held head issues nothing in the same cycle
  a_hold_source: assert property (interlock_stall_reg |->
    !dp_issue_reg && !lsp_issue_reg) else $error("issue while held");
  a_gpr_pending: assert property (xfer_valid_reg && !host_xfer_ack |=>
    gpr_stall_reg) else $error("transfer not pending");
  a_fmt_answer: assert property (fmt_valid |=> fmt_out_valid_reg)
    else $error("format answer late");
endmodule

bind simd_issue_scheduler sched_chk sched_chk_i (.sys_clk, .rstn, .host_valid,
  .host_stall_reg, .retire_reg, .undef_exc_reg, .lsp_issue_reg, .lsp_cls_reg,
  .dp_issue_reg, .dp_unit_reg, .dual_issue_reg, .interlock_stall_reg,
  .xfer_valid_reg, .host_xfer_ack, .gpr_stall_reg, .fmt_valid, .fmt_out_valid_reg);

/* File: test/host_model.sv */
`timescale 1ns/100ps
module host_model (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic xfer_valid_reg,
  input wire logic [3:0] ack_gap,
  output logic host_xfer_ack = 1'b0
);
  int pend;
  int wait_cnt;

  // Core drains transfers one at a time; a large gap mimics a busy core
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      pend = 0;
      wait_cnt = 0;
      host_xfer_ack <= 1'b0;
    end else begin
      pend = pend + int'(xfer_valid_reg === 1'b1);
      // Ack is assigned once per edge, so the pulse never glitches within a step
      host_xfer_ack <= pend > 0 && wait_cnt >= int'(ack_gap);
      if (pend > 0 && wait_cnt >= int'(ack_gap)) begin
        pend = pend - 1;
        wait_cnt = 0;
      end else if (pend > 0) begin
        wait_cnt = wait_cnt + 1;
      end
    end
  end
endmodule

/* File: test/tb_top.sv */
`timescale 1ns/100ps
module tb_top;
  import sched_pkg::*;
  typedef struct {kind_type k; logic st, q; logic [2:0] w; logic [1:0] e;
    logic [4:0] a; logic [1:0] al; logic f;} row_type;
  logic sys_clk = 1'b0, rstn = 1'b0, simd_present = 1'b0, host_valid = 1'b0;
  cls_type host_cls = CLS_DP;
  logic [2:0] host_unit = 3'h4, host_cycles = 3'h1, host_latency = 3'h1;
  logic [4:0] host_dst = 5'h00, host_src1 = 5'h00, host_src2 = 5'h00;
  logic host_dst_quad = 1'b0, host_src_quad = 1'b0;
  logic [31:0] host_data = 32'h0000_0000;
  logic fmt_valid = 1'b0, fmt_store = 1'b0, fmt_quad = 1'b0;
  logic [2:0] fmt_ways = 3'h1;
  logic [1:0] fmt_esize = 2'h0, fmt_align = 2'h0;
  kind_type fmt_kind = KIND_CONTIG;
  logic [4:0] fmt_addr_lo = 5'h00;
  logic [255:0] fmt_data, exp_out, mask;
  logic [3:0] ack_gap = 4'h0;
  logic host_xfer_ack, host_stall_reg, retire_reg, undef_exc_reg, gpr_stall_reg;
  logic lsp_issue_reg, dp_issue_reg, dual_issue_reg, interlock_stall_reg;
  logic xfer_valid_reg, fmt_out_valid_reg, align_fault_reg;
  cls_type lsp_cls_reg, last_cls;
  logic [2:0] dp_unit_reg, last_unit;
  logic [31:0] xfer_data_reg;
  logic [255:0] fmt_out_reg;
  logic [31:0] xd[$];
  int num_errors = 0, checks_done = 0;
  int n_ret, n_und, n_lsp, n_dp, n_dual, n_ilk, n_gpr, n_stall;
  row_type rows [12] = '{
    '{KIND_CONTIG, 0, 0, 1, 0, 5'h03, 0, 0}, '{KIND_STRUCT, 0, 0, 2, 1, 5'h01, 0, 0},
    '{KIND_STRUCT, 0, 0, 3, 0, 5'h00, 0, 0}, '{KIND_STRUCT, 0, 0, 4, 2, 5'h00, 0, 0},
    '{KIND_STRUCT, 0, 1, 2, 1, 5'h00, 0, 0}, '{KIND_STRUCT, 1, 0, 2, 1, 5'h00, 0, 0},
    '{KIND_STRUCT, 1, 0, 3, 2, 5'h00, 0, 0}, '{KIND_STRUCT, 0, 0, 2, 0, 5'h04, 1, 1},
    '{KIND_STRUCT, 0, 0, 2, 0, 5'h08, 2, 1}, '{KIND_STRUCT, 0, 0, 2, 0, 5'h10, 3, 1},
    '{KIND_MULTI_REG, 0, 0, 1, 0, 5'h04, 0, 0}, '{KIND_SINGLE_REG, 1, 0, 1, 0, 5'h02, 0, 1}};

  always #50 sys_clk = ~sys_clk;

  simd_issue_scheduler #(.IQ_AW(2), .DQ_DEPTH(2)) simd_issue_scheduler_i (.*);
  host_model host_model_i (.*);

  // Outputs are tallied mid-cycle, where they are settled
  always @(negedge sys_clk) begin
    n_ret += int'(retire_reg === 1'b1);
    n_und += int'(undef_exc_reg === 1'b1);
    n_dual += int'(dual_issue_reg === 1'b1);
    n_ilk += int'(interlock_stall_reg === 1'b1);
    n_gpr += int'(gpr_stall_reg === 1'b1);
    n_stall += int'(host_stall_reg === 1'b1);
    if (dp_issue_reg === 1'b1) begin
      n_dp++;
      last_unit = dp_unit_reg;
    end
    if (lsp_issue_reg === 1'b1) begin
      n_lsp++;
      last_cls = lsp_cls_reg;
    end
    if (xfer_valid_reg === 1'b1) xd.push_back(xfer_data_reg);
  end

  function automatic bit ck(bit bad);
    checks_done++;
    return bad;
  endfunction

  task automatic fail(string m);
    num_errors++;
    $display("mismatch at %0t: %s", $time, m);
  endtask

  task automatic clr;
    {n_ret, n_und, n_lsp, n_dp, n_dual, n_ilk, n_gpr, n_stall} = '0;
    xd.delete();
  endtask

  // Offer is held while back-pressure is up, and leaves just after the taking edge
  task automatic offer(cls_type c, logic [4:0] d, s, logic [2:0] cyc, lat);
    host_valid <= 1'b1;
    host_cls <= c;
    host_dst <= d;
    host_src1 <= s;
    host_cycles <= cyc;
    host_latency <= lat;
    @(negedge sys_clk);
    while (host_stall_reg !== 1'b0) @(negedge sys_clk);
    @(posedge sys_clk);
  endtask

  task automatic idle(int n);
    host_valid <= 1'b0;
    repeat (n) @(posedge sys_clk);
  endtask

  // Expected format result: lane byte b of way w comes from element w of structure b/e
  task automatic fmt_calc(row_type r);
    int p, n, e, w, b, s;
    p = r.q ? 16 : 8;
    e = 1 << r.e;
    n = (r.k == KIND_STRUCT) ? int'(r.w) * p : 32;
    exp_out = fmt_data;
    mask = '0;
    for (int o = 0; o < n; o++) begin
      mask[o*8 +: 8] = 8'hFF;
      w = o / p;
      b = o % p;
      s = ((b / e) * int'(r.w) + w) * e + b % e;
      if (r.k == KIND_STRUCT && r.st) exp_out[s*8 +: 8] = fmt_data[o*8 +: 8];
      else if (r.k == KIND_STRUCT) exp_out[o*8 +: 8] = fmt_data[s*8 +: 8];
    end
  endtask

  task automatic end_sim;
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Tests take well under a thousand cycles
  initial begin
    repeat (5000) @(posedge sys_clk);
    fail("watchdog expired");
    end_sim();
  end

  initial begin
    for (int i = 0; i < 32; i++) fmt_data[i*8 +: 8] = 8'(i * 7 + 1);
    repeat (5) @(posedge sys_clk);
    rstn <= 1'b1;
    @(negedge sys_clk);
    if (ck({host_stall_reg, retire_reg, gpr_stall_reg, lsp_issue_reg} !== 4'h0)) fail("reset");
    repeat (3) @(posedge sys_clk);
    clr();
    offer(CLS_DP, 5'h01, 5'h02, 1, 1);
    idle(3);
    if (ck(n_und != 1 || n_ret != 0)) fail("absent unit");
    simd_present <= 1'b1;
    idle(4);
    foreach (rows[r]) begin
      fmt_kind <= rows[r].k;
      {fmt_store, fmt_quad, fmt_ways} <= {rows[r].st, rows[r].q, rows[r].w};
      {fmt_esize, fmt_addr_lo, fmt_align, fmt_valid} <= {rows[r].e, rows[r].a, rows[r].al, 1'b1};
      fmt_calc(rows[r]);
      @(posedge sys_clk);
      fmt_valid <= 1'b0;
      @(negedge sys_clk);
      if (ck(align_fault_reg !== rows[r].f)) fail("alignment");
      if (ck(!rows[r].f && ((fmt_out_reg ^ exp_out) & mask) !== '0)) fail("format");
      // Hand-worked lanes: 16-bit pairs, even element to the first doubleword
      if (ck(r == 1 && {fmt_out_reg[79:64], fmt_out_reg[31:16]} !== 32'h160F_241D))
        fail("two-way lanes");
      @(posedge sys_clk);
    end
    // Held reader lets a queued load pair with it
    clr();
    offer(CLS_DP, 5'h01, 5'h14, 1, 4);
    offer(CLS_DP, 5'h15, 5'h01, 1, 1);
    offer(CLS_LOAD, 5'h16, 5'h17, 1, 1);
    offer(CLS_DP, 5'h18, 5'h19, 1, 1);
    idle(12);
    if (ck(n_dual != 1 || n_lsp != 1 || n_dp != 3 || n_ilk == 0)) fail("pairing");
    if (ck(last_cls !== CLS_LOAD || last_unit !== 3'h4)) fail("pipe routing");
    if (ck(n_ret != 4 || n_stall != 0)) fail("host held by a short queue");
    // Three-cycle op pairs only with the newer store on its last cycle
    clr();
    offer(CLS_DP, 5'h02, 5'h14, 1, 4);
    offer(CLS_DP, 5'h1A, 5'h02, 1, 1);
    offer(CLS_DP, 5'h1B, 5'h1C, 3, 1);
    offer(CLS_STORE, 5'h1D, 5'h1E, 1, 1);
    idle(14);
    if (ck(n_dp != 5 || n_dual != 1 || n_lsp != 1)) fail("multi-cycle issue");
    // Reader of either half of quad 3, or of an unrelated register
    for (int k = 0; k < 3; k++) begin
      clr();
      host_dst_quad <= 1'b1;
      offer(CLS_LONG_ADD, 5'h03, 5'h01, 1, 1);
      host_dst_quad <= 1'b0;
      offer(CLS_DP, 5'h10, 5'(6 + k), 1, 1);
      idle(8);
      if (ck(n_ilk != int'(k < 2))) fail("long add forward");
    end
    // Transfers toward the core with a prompt and a slow core
    for (int g = 0; g < 7; g += 6) begin
      clr();
      ack_gap <= 4'(g);
      host_data <= 32'hA5A5_5A5A;
      offer(CLS_SYSREG_WR, 5'h00, 5'h00, 1, 1);
      offer(CLS_SYSREG_RD, 5'h00, 5'h00, 1, 1);
      offer(CLS_MOV_TO_CORE, 5'h00, 5'h05, 1, 1);
      offer(CLS_MOV_FROM_CORE, 5'h09, 5'h00, 1, 1);
      idle(30);
      if (ck(xd.size() != 2 || xd[0] !== 32'hA5A5_5A5A)) fail("system read");
      if (ck(xd.size() != 2 || xd[1] !== 32'h0000_0005)) fail("move to core");
      if (ck(n_gpr < g + 1 || gpr_stall_reg !== 1'b0)) fail("gpr wait");
      if (ck(last_cls !== CLS_MOV_FROM_CORE)) fail("move from core");
    end
    // Loads behind a slow producer fill the data queue
    clr();
    offer(CLS_DP, 5'h04, 5'h14, 1, 7);
    repeat (6) offer(CLS_LOAD, 5'h0B, 5'h04, 1, 1);
    idle(20);
    if (ck(n_stall == 0)) fail("no back-pressure");
    if (ck(n_ret != 7 || n_lsp != 6)) fail("retire count");
    // Reset in mid-run, while back-pressure and a held reader are up
    offer(CLS_DP, 5'h04, 5'h14, 1, 7);
    repeat (2) offer(CLS_LOAD, 5'h0B, 5'h04, 1, 1);
    host_valid <= 1'b0;
    rstn <= 1'b0;
    @(negedge sys_clk);
    if (ck({host_stall_reg, interlock_stall_reg, retire_reg, xfer_valid_reg} !== 4'h0))
      fail("mid-run reset");
    @(posedge sys_clk);
    rstn <= 1'b1;
    idle(4);
    clr();
    // Scoreboard was cleared, so a reader of the old destination goes at once
    offer(CLS_DP, 5'h05, 5'h04, 1, 1);
    idle(4);
    if (ck(n_ilk != 0 || n_ret != 1 || n_dp != 1 || n_und != 0)) fail("after reset");
    end_sim();
  end
endmodule
